// file: design/zcl_edge.sv
/*
 * zcl_edge: registers a logic level and flags its rising and falling edges.
 * assumes: level_i is already in the clock_i domain.
 */
`timescale 1ns/1ps
`default_nettype none
module zcl_edge
    import zcl_pkg::*;
(
    input  wire logic clock_i,  // system clock
    input  wire logic arst_n_i, // async reset, active low
    input  wire logic ce_i,     // clock enable
    input  wire logic level_i,  // level to watch
    output logic      level_o,  // registered level
    output logic      rise_o,   // one-cycle pulse on low-to-high
    output logic      fall_o    // one-cycle pulse on high-to-low
);
    // edges compare the new level against the held one
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            level_o <= ZCL_RST_BIT;
            rise_o  <= ZCL_RST_BIT;
            fall_o  <= ZCL_RST_BIT;
        end else if (ce_i) begin
            level_o <= level_i;
            rise_o  <= level_i & ~level_o;
            fall_o  <= ~level_i & level_o;
        end
    end
endmodule
`default_nettype wire

// file: design/zcl_pkg.sv
/*
 * zcl_pkg: shared constants of the zero-cross logic and interrupt block:
 * register byte offsets, field positions, reset values, bus response codes.
 * assumes: a 32-bit AXI4-Lite register bus with byte addressing.
 */
package zcl_pkg;
    // register byte offsets
    localparam logic [7:0] ZCL_OFS_CTRL   = 8'h00; // crossing_control_reg
    localparam logic [7:0] ZCL_OFS_STATUS = 8'h04; // peripheral_irq_flags_three
    localparam logic [7:0] ZCL_OFS_MASK   = 8'h08; // peripheral_irq_enable_three
    localparam logic [7:0] ZCL_OFS_GATE   = 8'h0C; // irq_control_reg
    // crossing_control_reg fields
    localparam int ZCL_BIT_ENABLE = 7; // crossing_detect_enable
    localparam int ZCL_BIT_LEVEL  = 5; // crossing_logic_level, read only
    localparam int ZCL_BIT_INVERT = 4; // crossing_output_invert
    localparam int ZCL_BIT_RISE   = 1; // crossing_rise_irq_enable
    localparam int ZCL_BIT_FALL   = 0; // crossing_fall_irq_enable
    // status and mask field
    localparam int ZCL_BIT_FLAG   = 4; // crossing_irq_flag / crossing_irq_enable
    // irq_control_reg fields
    localparam int ZCL_BIT_GLOBAL = 7; // global_irq_gate
    localparam int ZCL_BIT_PERIPH = 6; // peripheral_irq_gate
    // reset values
    localparam logic ZCL_RST_BIT = 1'b0;
    localparam logic [31:0] ZCL_RST_WORD = 32'h0000_0000;
    // strap is sampled once the strap synchroniser has settled
    localparam logic [1:0] ZCL_STRAP_WAIT = 2'h3;
    // bus responses
    localparam logic [1:0] ZCL_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ZCL_RESP_SLVERR = 2'h2;
endpackage

// file: design/zcl_sync.sv
/*
 * zcl_sync: two flip-flop synchroniser for pin levels.
 * assumes: inputs are asynchronous levels; the first stage feeds only the second.
 */
`timescale 1ns/1ps
`default_nettype none
module zcl_sync
    import zcl_pkg::*;
#(
    parameter int WIDTH = 1  // number of independent levels
) (
    input  wire logic             clock_i,  // system clock
    input  wire logic             arst_n_i, // async reset, active low
    input  wire logic             ce_i,     // clock enable
    input  wire logic [WIDTH-1:0] async_i,  // raw pin levels
    output logic      [WIDTH-1:0] sync_o    // levels in clock_i domain
);
    logic [WIDTH-1:0] stage1; // metastable stage, read only by sync_o

    // two stages; the first is never looked at by logic
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else if (ce_i) begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule
`default_nettype wire

// file: design/zcl_top.sv
/*
 * zcl_top: digital side of a zero-cross detector with an AXI4-Lite slave.
 * assumes: sense_i high while the analog stage sinks current; pin_*_i come
 * from pin routing logic on clock_i; default_off_cfg_i is a static strap.
 */
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module zcl_top
    import zcl_pkg::*;
(
    input  wire logic        clock_i,           // 100 MHz system clock
    input  wire logic        arst_n_i,          // async reset, active low
    input  wire logic        ce_i,              // clock enable, freezes all state
    input  wire logic        sense_i,           // comparator: 1 = sinking
    input  wire logic        default_off_cfg_i, // strap, crossing_default_off_cfg
    input  wire logic        sleep_i,           // low-power state, no effect here
    input  wire logic        pin_out_i,         // pin data from pin_select_map
    input  wire logic        pin_oe_i,          // drive from pin_direction_ctrl
    output logic             pin_out_o,         // pin data toward pad
    output logic             pin_oe_o,          // pad output enable
    output logic             pin_analog_o,      // pad forced into source/sink
    output logic             irq_o,             // level interrupt request
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // control and status state
    logic       detect_enable;  // crossing_detect_enable
    logic       output_invert;  // crossing_output_invert
    logic       rise_en;        // crossing_rise_irq_enable
    logic       fall_en;        // crossing_fall_irq_enable
    logic       irq_flag;       // crossing_irq_flag, sticky
    logic       irq_enable;     // crossing_irq_enable
    logic       periph_gate;    // peripheral_irq_gate
    logic       global_gate;    // global_irq_gate
    logic [1:0] strap_cnt;      // edges since reset release
    // bus state
    logic [7:0] aw_addr;        // captured write address
    logic [7:0] w_data;         // captured low byte of write data
    logic       w_lane0;        // low byte strobe captured
    logic       aw_held;        // address taken, waiting for data
    logic       w_held;         // data taken, waiting for address
    // pin side
    logic [1:0] pins_sync;      // sense and strap after synchroniser
    logic       level;          // crossing_logic_level
    logic       rise;           // rising edge pulse
    logic       fall;           // falling edge pulse

    // sense and strap come from outside the clock domain
    zcl_sync #(.WIDTH(2)) u_sync (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .ce_i     (ce_i),
        .async_i  ({default_off_cfg_i, sense_i}),
        .sync_o   (pins_sync)
    );

    // a disabled stage drives no current, so it reads as sourcing; inversion
    // is applied before the edge detectors so polarity steers both edges
    wire sense_s   = pins_sync[0] & detect_enable;
    wire level_raw = sense_s ^ output_invert;

    zcl_edge u_edge (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .ce_i     (ce_i),
        .level_i  (level_raw),
        .level_o  (level),
        .rise_o   (rise),
        .fall_o   (fall)
    );

    // write decode
    wire do_write  = aw_held & w_held & ~s_axi_bvalid;
    wire wr_ctrl   = do_write & w_lane0 & (aw_addr == ZCL_OFS_CTRL);
    wire wr_status = do_write & w_lane0 & (aw_addr == ZCL_OFS_STATUS);
    wire wr_mask   = do_write & w_lane0 & (aw_addr == ZCL_OFS_MASK);
    wire wr_gate   = do_write & w_lane0 & (aw_addr == ZCL_OFS_GATE);
    wire wr_hit    = (aw_addr == ZCL_OFS_CTRL) | (aw_addr == ZCL_OFS_STATUS)
                   | (aw_addr == ZCL_OFS_MASK) | (aw_addr == ZCL_OFS_GATE);
    wire aw_take   = s_axi_awvalid & s_axi_awready;
    wire w_take    = s_axi_wvalid & s_axi_wready;
    wire ar_take   = s_axi_arvalid & s_axi_arready;

    // interrupt event sources
    wire invert_chg = wr_ctrl & (w_data[ZCL_BIT_INVERT] != output_invert);
    wire edge_set   = (rise & rise_en) | (fall & fall_en);
    wire flag_set   = edge_set | invert_chg;
    wire flag_clr   = wr_status & w_data[ZCL_BIT_FLAG];
    // set beats clear so an edge in the clearing cycle is kept
    wire next_flag  = (irq_flag & ~flag_clr) | flag_set;
    wire next_irq   = next_flag & irq_enable & periph_gate & global_gate;

    // read mux
    wire [7:0] rd_ctrl = {detect_enable, 1'b0, level, output_invert,
                          2'b00, rise_en, fall_en};
    wire [7:0] rd_byte =
        (s_axi_araddr == ZCL_OFS_CTRL)   ? rd_ctrl :
        (s_axi_araddr == ZCL_OFS_STATUS) ? {3'b000, irq_flag, 4'h0} :
        (s_axi_araddr == ZCL_OFS_MASK)   ? {3'b000, irq_enable, 4'h0} :
        (s_axi_araddr == ZCL_OFS_GATE)   ? {global_gate, periph_gate, 6'h00} :
                                           8'h00;
    wire rd_hit = (s_axi_araddr == ZCL_OFS_CTRL) | (s_axi_araddr == ZCL_OFS_STATUS)
                | (s_axi_araddr == ZCL_OFS_MASK) | (s_axi_araddr == ZCL_OFS_GATE);

    // strap: reset can only load constants, so the enable is loaded from the
    // synchronised strap once it has settled after release
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strap_cnt <= 2'h0;
        end else if (ce_i && strap_cnt != ZCL_STRAP_WAIT) begin
            strap_cnt <= strap_cnt + 2'h1;
        end
    end
    wire strap_load = (strap_cnt == ZCL_STRAP_WAIT - 2'h1);

    // control register
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            detect_enable <= ZCL_RST_BIT;
            output_invert <= ZCL_RST_BIT;
            rise_en       <= ZCL_RST_BIT;
            fall_en       <= ZCL_RST_BIT;
        end else if (ce_i) begin
            if (strap_load) begin
                detect_enable <= ~pins_sync[1];
            end
            if (wr_ctrl) begin
                detect_enable <= w_data[ZCL_BIT_ENABLE];
                output_invert <= w_data[ZCL_BIT_INVERT];
                rise_en       <= w_data[ZCL_BIT_RISE];
                fall_en       <= w_data[ZCL_BIT_FALL];
            end
        end
    end

    // flag, mask, gates and the interrupt line; sleep_i gates nothing here
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_flag    <= ZCL_RST_BIT;
            irq_enable  <= ZCL_RST_BIT;
            periph_gate <= ZCL_RST_BIT;
            global_gate <= ZCL_RST_BIT;
            irq_o       <= ZCL_RST_BIT;
        end else if (ce_i) begin
            irq_flag <= next_flag;
            irq_o    <= next_irq;
            if (wr_mask) begin
                irq_enable <= w_data[ZCL_BIT_FLAG];
            end
            if (wr_gate) begin
                global_gate <= w_data[ZCL_BIT_GLOBAL];
                periph_gate <= w_data[ZCL_BIT_PERIPH];
            end
        end
    end

    // pad control: forced into source/sink drive while detecting
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_analog_o <= ZCL_RST_BIT;
            pin_oe_o     <= ZCL_RST_BIT;
            pin_out_o    <= ZCL_RST_BIT;
        end else if (ce_i) begin
            pin_analog_o <= detect_enable;
            pin_oe_o     <= pin_oe_i & ~detect_enable;
            pin_out_o    <= pin_out_i;
        end
    end

    // write channels: address and data taken in either order, one at a time
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_held       <= ZCL_RST_BIT;
            w_held        <= ZCL_RST_BIT;
            aw_addr       <= 8'h00;
            w_data        <= 8'h00;
            w_lane0       <= ZCL_RST_BIT;
            s_axi_awready <= ZCL_RST_BIT;
            s_axi_wready  <= ZCL_RST_BIT;
            s_axi_bvalid  <= ZCL_RST_BIT;
            s_axi_bresp   <= ZCL_RESP_OKAY;
        end else if (ce_i) begin
            if (!aw_held && !s_axi_awready && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (!w_held && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (aw_take) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata[7:0];
                w_lane0      <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? ZCL_RESP_OKAY : ZCL_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end
        end
    end

    // read channel: one read at a time, data registered on address take
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_arready <= ZCL_RST_BIT;
            s_axi_rvalid  <= ZCL_RST_BIT;
            s_axi_rdata   <= ZCL_RST_WORD;
            s_axi_rresp   <= ZCL_RESP_OKAY;
        end else if (ce_i) begin
            if (!s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h00_0000, rd_byte};
                s_axi_rresp   <= rd_hit ? ZCL_RESP_OKAY : ZCL_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    property p_level_polarity;
        ce_i ##1 ce_i |-> level == $past(level_raw);
    endproperty
    a_level_polarity: assert property (p_level_polarity)
        else $error("logic level does not follow sense and invert");

    property p_invert_flips;
        ce_i && $past(ce_i) && $changed(output_invert) && $stable(sense_s)
            |-> level_raw != $past(level_raw);
    endproperty
    a_invert_flips: assert property (p_invert_flips)
        else $error("invert change did not flip the level");

    property p_sync_delay;
        ce_i [*3] ##0 $past(arst_n_i, 2) |-> pins_sync[0] == $past(sense_i, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("sense not delayed by two stages");

    property p_rise_sets;
        ce_i && rise && rise_en |=> irq_flag;
    endproperty
    a_rise_sets: assert property (p_rise_sets)
        else $error("enabled rising edge lost");

    property p_edge_after_invert;
        ce_i && $past(ce_i) && rise |-> level && !$past(level);
    endproperty
    a_edge_after_invert: assert property (p_edge_after_invert)
        else $error("rise pulse without a level rise");

    property p_invert_event;
        ce_i && invert_chg |=> irq_flag;
    endproperty
    a_invert_event: assert property (p_invert_event)
        else $error("invert change raised no event");

    property p_flag_sticky;
        ce_i && irq_flag && !flag_clr |=> irq_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag dropped without a clear");

    property p_set_wins;
        ce_i && flag_clr && flag_set |=> irq_flag;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a simultaneous event");

    property p_irq_gated;
        ce_i ##1 irq_o |-> $past(irq_enable & periph_gate & global_gate);
    endproperty
    a_irq_gated: assert property (p_irq_gated)
        else $error("interrupt raised while gated");

    property p_pin_forced;
        ce_i && detect_enable |=> !pin_oe_o && pin_analog_o;
    endproperty
    a_pin_forced: assert property (p_pin_forced)
        else $error("pad not forced while detecting");

    property p_strap;
        ce_i && strap_load && !wr_ctrl |=> detect_enable == !$past(pins_sync[1]);
    endproperty
    a_strap: assert property (p_strap)
        else $error("enable not taken from strap");

    property p_sleep_free;
        ce_i && sleep_i && fall && fall_en |=> irq_flag;
    endproperty
    a_sleep_free: assert property (p_sleep_free)
        else $error("edge lost during sleep");
endmodule
`default_nettype wire

// file: tb/zcl_analog_model.sv
/*
 * zcl_analog_model: behavioural current source/sink stage on the sensing pin.
 * assumes: above_i tells whether the applied voltage lies above the reference.
 */
`timescale 1ns/1ps
`default_nettype none
module zcl_analog_model (
    input  wire logic clock_i,  // system clock, paces the idle pattern only
    input  wire logic forced_i, // pin forced into source/sink drive
    input  wire logic above_i,  // applied voltage above the reference
    output logic      sense_o   // high while the stage sinks current
);
    logic idle_q = 1'b0; // junk shown while the stage is not driving
    // idle pattern changes every cycle so a design that trusts it shows edges
    always_ff @(posedge clock_i) begin
        idle_q <= ~idle_q;
    end
    // sink above the reference, source below; no sense unless forced
    assign sense_o = forced_i ? above_i : idle_q;
endmodule
`default_nettype wire

// file: tb/zero_cross_logic_irq_test.sv
/*
 * zero_cross_logic_irq_test: self-checking bench for zcl_top.
 * assumes: zcl_analog_model on the sensing pin; bus latencies as handed over.
 */
`timescale 1ns/1ps
`default_nettype none
module zero_cross_logic_irq_test;
    import zcl_pkg::*;
    logic        clock_i = 1'b0;  // 100 MHz system clock
    logic        arst_n_i = 1'b0; // async reset, held at start
    logic        strap = 1'b1;    // default-off strap
    logic        sleep = 1'b0;    // low-power indication
    logic        pin_out = 1'b0;  // routed pin data
    logic        pin_oe = 1'b0;   // routed pin direction
    logic        above = 1'b0;    // applied voltage above reference
    logic        sense;           // comparator sense from the model
    logic        pin_out_o, pin_oe_o, pin_analog_o, irq_o;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [1:0]  bresp, rresp;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    int          n_errors = 0;    // mismatches
    int          n_tests = 0;     // comparisons
    int          cycles = 0;      // hang guard
    // free-running clock
    always #5 clock_i = ~clock_i;
    zcl_analog_model u_analog (.clock_i(clock_i), .forced_i(pin_analog_o),
        .above_i(above), .sense_o(sense));
    zcl_top u_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(1'b1),
        .sense_i(sense), .default_off_cfg_i(strap), .sleep_i(sleep),
        .pin_out_i(pin_out), .pin_oe_i(pin_oe), .pin_out_o(pin_out_o),
        .pin_oe_o(pin_oe_o), .pin_analog_o(pin_analog_o), .irq_o(irq_o),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // compare and report at once
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    // one write; each channel released when taken, bready held until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        // one edge passes so the next task never drives in the same step
        @(posedge clock_i);
    endtask
    // one read, data and response judged against the expectation
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock_i);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge clock_i);
    endtask
    // clear the flag, move the applied voltage, then judge the flag
    task automatic edge_case(input logic lvl, input logic [31:0] flag);
        repeat (8) @(posedge clock_i);
        wr(ZCL_OFS_STATUS, 32'h10, ZCL_RESP_OKAY);
        above <= lvl;
        repeat (8) @(posedge clock_i);
        rd(ZCL_OFS_STATUS, flag, ZCL_RESP_OKAY);
    endtask
    task automatic t_reset();
        rd(ZCL_OFS_CTRL, 32'h0, ZCL_RESP_OKAY);
        rd(ZCL_OFS_STATUS, 32'h0, ZCL_RESP_OKAY);
        rd(ZCL_OFS_MASK, 32'h0, ZCL_RESP_OKAY);
        rd(ZCL_OFS_GATE, 32'h0, ZCL_RESP_OKAY);
        // unmapped place is refused both ways and leaves control alone
        rd(8'h10, 32'h0, ZCL_RESP_SLVERR);
        wr(8'h10, 32'hff, ZCL_RESP_SLVERR);
        rd(ZCL_OFS_CTRL, 32'h0, ZCL_RESP_OKAY);
        chk({31'h0, irq_o}, 32'h0);
        $display("t_reset done, errors %0d", n_errors);
    endtask
    task automatic t_pins();
        pin_out <= 1'b1;
        pin_oe <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk({30'h0, pin_out_o, pin_oe_o}, 32'h3);
        wr(ZCL_OFS_CTRL, 32'h80, ZCL_RESP_OKAY);
        repeat (3) @(posedge clock_i);
        chk({30'h0, pin_oe_o, pin_analog_o}, 32'h1);
        wr(ZCL_OFS_CTRL, 32'h0, ZCL_RESP_OKAY);
        pin_out <= 1'b0;
        repeat (3) @(posedge clock_i);
        chk({29'h0, pin_out_o, pin_oe_o, pin_analog_o}, 32'h2);
        $display("t_pins done, errors %0d", n_errors);
    endtask
    task automatic t_level();
        wr(ZCL_OFS_CTRL, 32'h80, ZCL_RESP_OKAY);
        above <= 1'b1;
        repeat (8) @(posedge clock_i);
        rd(ZCL_OFS_CTRL, 32'ha0, ZCL_RESP_OKAY);
        above <= 1'b0;
        repeat (8) @(posedge clock_i);
        rd(ZCL_OFS_CTRL, 32'h80, ZCL_RESP_OKAY);
        wr(ZCL_OFS_CTRL, 32'h90, ZCL_RESP_OKAY);
        repeat (4) @(posedge clock_i);
        rd(ZCL_OFS_CTRL, 32'hb0, ZCL_RESP_OKAY);
        above <= 1'b1;
        repeat (8) @(posedge clock_i);
        rd(ZCL_OFS_CTRL, 32'h90, ZCL_RESP_OKAY);
        // invert flips with the detector off and no edge enables
        wr(ZCL_OFS_CTRL, 32'h0, ZCL_RESP_OKAY);
        wr(ZCL_OFS_STATUS, 32'h10, ZCL_RESP_OKAY);
        wr(ZCL_OFS_CTRL, 32'h10, ZCL_RESP_OKAY);
        rd(ZCL_OFS_STATUS, 32'h10, ZCL_RESP_OKAY);
        rd(ZCL_OFS_CTRL, 32'h30, ZCL_RESP_OKAY);
        wr(ZCL_OFS_STATUS, 32'h10, ZCL_RESP_OKAY);
        wr(ZCL_OFS_CTRL, 32'h0, ZCL_RESP_OKAY);
        rd(ZCL_OFS_STATUS, 32'h10, ZCL_RESP_OKAY);
        $display("t_level done, errors %0d", n_errors);
    endtask
    task automatic t_edges();
        sleep <= 1'b1;
        above <= 1'b0;
        wr(ZCL_OFS_CTRL, 32'h82, ZCL_RESP_OKAY);
        edge_case(1'b1, 32'h10);
        edge_case(1'b0, 32'h0);
        wr(ZCL_OFS_CTRL, 32'h81, ZCL_RESP_OKAY);
        edge_case(1'b1, 32'h0);
        edge_case(1'b0, 32'h10);
        // inverted: a rising sense is a falling output
        wr(ZCL_OFS_CTRL, 32'h91, ZCL_RESP_OKAY);
        edge_case(1'b1, 32'h10);
        edge_case(1'b0, 32'h0);
        sleep <= 1'b0;
        $display("t_edges done, errors %0d", n_errors);
    endtask
    task automatic t_irq();
        wr(ZCL_OFS_CTRL, 32'h82, ZCL_RESP_OKAY);
        above <= 1'b0;
        edge_case(1'b1, 32'h10);
        // every mix of enable and both gates; only all three raise it
        for (int i = 0; i < 8; i++) begin
            wr(ZCL_OFS_MASK, {27'h0, i[0], 4'h0}, ZCL_RESP_OKAY);
            wr(ZCL_OFS_GATE, {24'h0, i[2], i[1], 6'h0}, ZCL_RESP_OKAY);
            repeat (2) @(posedge clock_i);
            chk({31'h0, irq_o}, {31'h0, i == 7});
        end
        wr(ZCL_OFS_STATUS, 32'h0, ZCL_RESP_OKAY);
        repeat (40) @(posedge clock_i);
        rd(ZCL_OFS_STATUS, 32'h10, ZCL_RESP_OKAY);
        wr(ZCL_OFS_STATUS, 32'h10, ZCL_RESP_OKAY);
        repeat (2) @(posedge clock_i);
        chk({31'h0, irq_o}, 32'h0);
        rd(ZCL_OFS_STATUS, 32'h0, ZCL_RESP_OKAY);
        $display("t_irq done, errors %0d", n_errors);
    endtask
    // clear issued k cycles after a crossing; k of 2 lands on the set
    task automatic t_race();
        wr(ZCL_OFS_CTRL, 32'h83, ZCL_RESP_OKAY);
        for (int k = 0; k < 6; k++) begin
            repeat (8) @(posedge clock_i);
            wr(ZCL_OFS_STATUS, 32'h10, ZCL_RESP_OKAY);
            repeat (8) @(posedge clock_i);
            fork
                above <= ~above;
                begin
                    repeat (k) @(posedge clock_i);
                    wr(ZCL_OFS_STATUS, 32'h10, ZCL_RESP_OKAY);
                end
            join
            repeat (8) @(posedge clock_i);
            rd(ZCL_OFS_STATUS, {27'h0, k <= 2, 4'h0}, ZCL_RESP_OKAY);
        end
        $display("t_race done, errors %0d", n_errors);
    endtask
    task automatic t_strap();
        arst_n_i <= 1'b0;
        strap <= 1'b0;
        // a quiet input keeps the level at zero once the pad is forced
        above <= 1'b0;
        repeat (10) @(posedge clock_i);
        arst_n_i <= 1'b1;
        // strap load, pad forcing and the synchroniser all settle first
        repeat (12) @(posedge clock_i);
        rd(ZCL_OFS_CTRL, 32'h80, ZCL_RESP_OKAY);
        chk({31'h0, pin_analog_o}, 32'h1);
        $display("t_strap done, errors %0d", n_errors);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // hang guard, far above the several hundred cycles the run needs
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        t_reset();
        t_pins();
        t_level();
        t_edges();
        t_irq();
        t_race();
        t_strap();
        give_verdict();
    end
endmodule
`default_nettype wire
